/* rtl/anst_regs.svh */
// timing counts, vectors, widths and opcode layouts for the execution slice
// assumes inclusion by bare name from rtl files
`ifndef ANST_REGS_SVH
`define ANST_REGS_SVH
`define ANST_ACC_W        32
`define ANST_PC_W         16
`define ANST_AR_W         16
`define ANST_AR_NUM       8
`define ANST_STACK_DEPTH  8
`define ANST_WAIT_W       4
`define ANST_RPT_W        8
`define ANST_TRAP_VECTOR  16'h0024
`define ANST_ACC_MOST_NEG 32'h80000000
`define ANST_ACC_MOST_POS 32'h7FFFFFFF
`define ANST_ACC_ZERO     32'h00000000
`define ANST_SINGLE_CYC   4'h1
`define ANST_TRAP_CYC     4'h4
`define ANST_TRAP_WAIT_MUL 4'h3
`define ANST_SPEC_WORDS   2'h2
`define ANST_OPC_NEG      16'hBE02
`define ANST_OPC_NOP      16'h8B00
`define ANST_OPC_TRAP     16'hBE52
`define ANST_OPC_SIGN_STRIP_STEP_OP_HI  8'hA0
`define ANST_IND_BIT      7
`endif

/* rtl/anst_pkg.sv */
// types shared by the execution slice
// assumes nothing beyond the constants header
package anst_pkg;
   typedef enum logic [2:0] {
      ANST_OP_NOP,
      ANST_OP_NEG,
      ANST_OP_SIGN_STRIP_STEP_OP,
      ANST_OP_TRAP,
      ANST_OP_OTHER
   } anst_op_t;
   typedef enum logic [2:0] {
      ANST_AR_KEEP,
      ANST_AR_INC,
      ANST_AR_DEC,
      ANST_AR_ADD0,
      ANST_AR_SUB0
   } anst_armod_t;
endpackage

/* rtl/anst_decode.sv */
// instruction word decoder: picks the operation and the aux modification
// assumes a stable word on the input, purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "anst_regs.svh"
module anst_decode (
   input  wire logic [15:0]         word_i,
   output anst_pkg::anst_op_t       op_o,
   output anst_pkg::anst_armod_t    armod_o
);
   always_comb begin
      op_o    = anst_pkg::ANST_OP_OTHER;
      armod_o = anst_pkg::ANST_AR_KEEP;
      if (word_i == `ANST_OPC_NEG) begin
         op_o = anst_pkg::ANST_OP_NEG;
      end else if (word_i == `ANST_OPC_NOP) begin
         op_o = anst_pkg::ANST_OP_NOP;
      end else if (word_i == `ANST_OPC_TRAP) begin
         op_o = anst_pkg::ANST_OP_TRAP;
      end else if (word_i[15:8] == `ANST_OPC_SIGN_STRIP_STEP_OP_HI && word_i[`ANST_IND_BIT]) begin
         op_o = anst_pkg::ANST_OP_SIGN_STRIP_STEP_OP;
         // bits 6:4 choose the modification; plain star leaves the register alone
         unique case (word_i[6:4])
            3'h0:    armod_o = anst_pkg::ANST_AR_KEEP;
            3'h1:    armod_o = anst_pkg::ANST_AR_DEC;
            3'h2:    armod_o = anst_pkg::ANST_AR_INC;
            3'h5:    armod_o = anst_pkg::ANST_AR_SUB0;
            3'h6:    armod_o = anst_pkg::ANST_AR_ADD0;
            default: armod_o = anst_pkg::ANST_AR_INC;
         endcase
      end
   end
endmodule // anst_decode
`default_nettype wire

/* rtl/anst_stack.sv */
// hardware return stack held in flip-flops
// assumes push requests come from the core clock domain
`timescale 1ns/1ps
`default_nettype none
`include "anst_regs.svh"
module anst_stack (
   input  wire logic                     clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     push_i,
   input  wire logic [`ANST_PC_W-1:0]    data_i,
   output logic      [`ANST_PC_W-1:0]    top_o,
   output logic      [3:0]               depth_o
);
   logic [`ANST_PC_W-1:0] entry [`ANST_STACK_DEPTH];
   // push shifts every entry down one place, the oldest drops off
   genvar g;
   generate
      for (g = 0; g < `ANST_STACK_DEPTH; g++) begin : g_entry
         if (g == 0) begin : g_head
            always_ff @(posedge clk_i or posedge reset_i) begin
               if (reset_i) begin
                  entry[g] <= 16'h0000;
               end else if (push_i) begin
                  entry[g] <= data_i;
               end
            end
         end else begin : g_tail
            // the index below zero is never elaborated
            always_ff @(posedge clk_i or posedge reset_i) begin
               if (reset_i) begin
                  entry[g] <= 16'h0000;
               end else if (push_i) begin
                  entry[g] <= entry[g-1];
               end
            end
         end
      end
   endgenerate
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         depth_o <= 4'h0;
      end else if (push_i && depth_o != 4'(`ANST_STACK_DEPTH)) begin
         depth_o <= depth_o + 4'h1;
      end
   end
   assign top_o = entry[0];
endmodule // anst_stack
`default_nettype wire

/* rtl/anst_core.sv */
// execution slice: negate, normalize step, software trap and no-operation
// assumes instruction words arrive with a valid strobe from the fetch side,
// and that the fetch side reports wait states of external program memory
//
// Behaviour
// RULE1 - negate overwrites result, program counter advances
// RULE2 - negate carry set only for zero value
// RULE3 - negating most negative sets wrap flag
// RULE4 - overflow saturates only when saturate enabled
// RULE5 - single word ops take one plus waits
// RULE6 - trap pushes incremented program counter
// RULE7 - trap jumps to vector 24h
// RULE8 - trap sets global interrupt mask always
// RULE9 - trap saves no context, only return
// RULE10 - trap not repeatable, four plus 3p
// RULE11 - two speculative words discarded on jump
// RULE12 - no-operation only advances program counter
// RULE13 - zero result sets test flag only
// RULE14 - equal top bits shift, else flag
// RULE15 - aux register modified, increment by default
// RULE16 - repeated normalize idles after completion
// RULE17 - software avoids aux hazards after normalize
// RULE18 - shift fills zero, keeps other flags
// RULE19 - trap leaves result, flags, aux untouched
`timescale 1ns/1ps
`default_nettype none
`include "anst_regs.svh"
module anst_core (
   input  wire logic                     clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     instr_valid_i,
   input  wire logic [15:0]              instr_word_i,
   input  wire logic                     instr_ext_i,
   input  wire logic [`ANST_WAIT_W-1:0]  wait_states_i,
   input  wire logic                     repeat_valid_i,
   input  wire logic [`ANST_RPT_W-1:0]   repeat_count_i,
   input  wire logic                     saturate_enable_i,
   input  wire logic [2:0]               aux_pointer_select_i,
   input  wire logic                     aux_load_i,
   input  wire logic [2:0]               aux_load_sel_i,
   input  wire logic [`ANST_AR_W-1:0]    aux_load_data_i,
   input  wire logic [`ANST_AR_W-1:0]    aux_index_i,
   input  wire logic                     acc_load_i,
   input  wire logic [`ANST_ACC_W-1:0]   acc_load_data_i,
   input  wire logic                     irq_mask_clear_i,
   output logic                          busy_o,
   output logic                          done_o,
   output logic                          flush_o,
   output logic [1:0]                    flush_words_o,
   output logic [`ANST_ACC_W-1:0]        main_result_register_o,
   output logic                          carry_o,
   output logic                          arith_wrap_flag_o,
   output logic                          test_flag_o,
   output logic                          global_irq_mask_o,
   output logic [`ANST_PC_W-1:0]         pc_o,
   output logic [`ANST_PC_W-1:0]         stack_top_o,
   output logic [3:0]                    stack_depth_o,
   output logic [`ANST_AR_W-1:0]         aux_register_o
);
   anst_pkg::anst_op_t    dec_op;
   anst_pkg::anst_armod_t dec_armod;
   anst_pkg::anst_op_t    cur_op;
   anst_pkg::anst_armod_t cur_armod;
   logic [2:0]               cur_arp;
   logic [`ANST_RPT_W-1:0]   iter_left;
   logic [3:0]               cyc_left;
   logic [3:0]               cyc_total;
   logic                     step;
   logic                     sign_strip_step_op_done;
   logic                     push;
   logic [`ANST_PC_W-1:0]    pc_inc;
   logic [`ANST_PC_W-1:0]    stack_top;
   logic [3:0]               stack_depth;
   logic [`ANST_AR_W-1:0]    aux [`ANST_AR_NUM];
   logic [`ANST_ACC_W-1:0]   acc_neg;
   logic                     acc_zero;
   logic                     top_equal;
   logic                     sign_strip_step_op_shift;
   logic                     accept;

   anst_decode u_decode (
      .word_i  (instr_word_i),
      .op_o    (dec_op),
      .armod_o (dec_armod)
   );

   // only the return address is stored on a trap
   anst_stack u_stack (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .push_i  (push),                                                         // RULE9
      .data_i  (pc_inc),
      .top_o   (stack_top),
      .depth_o (stack_depth)
   );

   assign accept    = instr_valid_i && !busy_o;
   assign pc_inc    = pc_o + 16'h0001;
   assign acc_zero  = (main_result_register_o == `ANST_ACC_ZERO);
   assign acc_neg   = `ANST_ACC_ZERO - main_result_register_o;
   assign top_equal = (main_result_register_o[31] == main_result_register_o[30]);
   assign sign_strip_step_op_shift = !acc_zero && top_equal && !sign_strip_step_op_done;
   // an execution step completes when the cycle counter reaches its last cycle
   assign step      = busy_o && (cyc_left == 4'h1);
   assign push      = step && cur_op == anst_pkg::ANST_OP_TRAP;                 // RULE6

   // cycles per execution: 1 (+p external), trap 4 (+3p external)
   always_comb begin
      if (dec_op == anst_pkg::ANST_OP_TRAP) begin
         cyc_total = instr_ext_i ? 4'(`ANST_TRAP_CYC + `ANST_TRAP_WAIT_MUL * wait_states_i)
                                 : `ANST_TRAP_CYC;                              // RULE10
      end else begin
         cyc_total = instr_ext_i ? 4'(`ANST_SINGLE_CYC + wait_states_i)
                                 : `ANST_SINGLE_CYC;                            // RULE5
      end
   end

   // sequencing of one instruction, repeated iterations included
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_o    <= 1'b0;
         cur_op    <= anst_pkg::ANST_OP_NOP;
         cur_armod <= anst_pkg::ANST_AR_KEEP;
         cur_arp   <= 3'h0;
         cyc_left  <= 4'h0;
         iter_left <= 8'h00;
      end else if (accept) begin
         busy_o    <= 1'b1;
         cur_op    <= dec_op;
         cur_armod <= dec_armod;
         cur_arp   <= aux_pointer_select_i;
         cyc_left  <= cyc_total;
         // a trap ignores the repeat prefix and runs once
         iter_left <= (repeat_valid_i && dec_op != anst_pkg::ANST_OP_TRAP)
                      ? repeat_count_i : 8'h00;                                  // RULE10
      end else if (step) begin
         if (iter_left != 8'h00) begin
            iter_left <= iter_left - 8'h01;
            cyc_left  <= `ANST_SINGLE_CYC;
         end else begin
            busy_o   <= 1'b0;
            cyc_left <= 4'h0;
         end
      end else if (busy_o) begin
         cyc_left <= cyc_left - 4'h1;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= step && iter_left == 8'h00;
      end
   end

   // once a repeated normalize finds the magnitude, later passes idle
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sign_strip_step_op_done <= 1'b0;
      end else if (accept) begin
         sign_strip_step_op_done <= 1'b0;
      end else if (step && cur_op == anst_pkg::ANST_OP_SIGN_STRIP_STEP_OP && !sign_strip_step_op_shift) begin
         sign_strip_step_op_done <= 1'b1;                                                     // RULE16
      end
   end

   // program counter: one word advance, or trap vector
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pc_o <= 16'h0000;
      end else if (step && iter_left == 8'h00) begin
         if (cur_op == anst_pkg::ANST_OP_TRAP) begin
            pc_o <= `ANST_TRAP_VECTOR;                                          // RULE7
         end else begin
            pc_o <= pc_inc;                                                     // RULE1 RULE12
         end
      end
   end

   // the two words already fetched past the trap are thrown away
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         flush_o       <= 1'b0;
         flush_words_o <= 2'h0;
      end else begin
         flush_o       <= push;                                                 // RULE11
         flush_words_o <= push ? `ANST_SPEC_WORDS : 2'h0;                       // RULE11
      end
   end

   // accumulator
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         main_result_register_o <= `ANST_ACC_ZERO;
      end else if (acc_load_i && !busy_o) begin
         main_result_register_o <= acc_load_data_i;
      end else if (step && cur_op == anst_pkg::ANST_OP_NEG) begin
         if (main_result_register_o == `ANST_ACC_MOST_NEG) begin
            main_result_register_o <= saturate_enable_i ? `ANST_ACC_MOST_POS
                                                        : `ANST_ACC_MOST_NEG;   // RULE4
         end else begin
            main_result_register_o <= acc_neg;                                  // RULE1
         end
      end else if (step && cur_op == anst_pkg::ANST_OP_SIGN_STRIP_STEP_OP && sign_strip_step_op_shift) begin
         main_result_register_o <= {main_result_register_o[30:0], 1'b0};        // RULE14 RULE18
      end
   end

   // carry and wrap change only on negate
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         carry_o <= 1'b0;
      end else if (step && cur_op == anst_pkg::ANST_OP_NEG) begin
         carry_o <= acc_zero;                                                   // RULE2
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         arith_wrap_flag_o <= 1'b0;
      end else if (step && cur_op == anst_pkg::ANST_OP_NEG &&
                   main_result_register_o == `ANST_ACC_MOST_NEG) begin
         arith_wrap_flag_o <= 1'b1;                                             // RULE3
      end
   end

   // test flag: set on zero or differing top bits, cleared on a shift
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         test_flag_o <= 1'b0;
      end else if (step && cur_op == anst_pkg::ANST_OP_SIGN_STRIP_STEP_OP && !sign_strip_step_op_done) begin
         test_flag_o <= !sign_strip_step_op_shift;                                            // RULE13 RULE14
      end
   end

   // mask set by trap whatever its prior value; software clear otherwise
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         global_irq_mask_o <= 1'b1;
      end else if (push) begin
         global_irq_mask_o <= 1'b1;                                             // RULE8
      end else if (irq_mask_clear_i) begin
         global_irq_mask_o <= 1'b0;
      end
   end

   // aux registers, written by the normalize step in execute
   genvar g;
   generate
      for (g = 0; g < `ANST_AR_NUM; g++) begin : g_aux
         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               aux[g] <= 16'h0000;
            end else if (aux_load_i && !busy_o && aux_load_sel_i == 3'(g)) begin
               aux[g] <= aux_load_data_i;
            end else if (step && cur_op == anst_pkg::ANST_OP_SIGN_STRIP_STEP_OP && sign_strip_step_op_shift &&
                         cur_arp == 3'(g)) begin
               unique case (cur_armod)                                          // RULE15
                  anst_pkg::ANST_AR_KEEP: aux[g] <= aux[g];
                  anst_pkg::ANST_AR_INC:  aux[g] <= aux[g] + 16'h0001;
                  anst_pkg::ANST_AR_DEC:  aux[g] <= aux[g] - 16'h0001;
                  anst_pkg::ANST_AR_ADD0: aux[g] <= aux[g] + aux_index_i;
                  anst_pkg::ANST_AR_SUB0: aux[g] <= aux[g] - aux_index_i;
               endcase
            end
         end
      end
   endgenerate

   // registered views of the stack and the selected aux register
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         stack_top_o    <= 16'h0000;
         stack_depth_o  <= 4'h0;
         aux_register_o <= 16'h0000;
      end else begin
         stack_top_o    <= stack_top;
         stack_depth_o  <= stack_depth;
         aux_register_o <= aux[aux_pointer_select_i];
      end
   end
endmodule // anst_core
`default_nettype wire

/* sim/anst_chk.sv */
// assertion checker for the execution slice, bound into anst_core
// assumes the ports and timing of anst_core on one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "anst_regs.svh"
module anst_chk (
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        instr_valid_i,
   input wire logic [15:0] instr_word_i,
   input wire logic        instr_ext_i,
   input wire logic        repeat_valid_i,
   input wire logic        saturate_enable_i,
   input wire logic        acc_load_i,
   input wire logic        busy_o,
   input wire logic        done_o,
   input wire logic        flush_o,
   input wire logic [1:0]  flush_words_o,
   input wire logic [31:0] main_result_register_o,
   input wire logic        carry_o,
   input wire logic        arith_wrap_flag_o,
   input wire logic        test_flag_o,
   input wire logic        global_irq_mask_o,
   input wire logic [15:0] pc_o,
   input wire logic [15:0] stack_top_o
);
   localparam logic [31:0] most_neg = `ANST_ACC_MOST_NEG;
   logic [31:0] acc;
   logic        go, neg, nop, nrm, trp;
   assign acc = main_result_register_o;
   // only internal fetches, so the fixed cycle figures apply
   assign go  = instr_valid_i && !busy_o && !acc_load_i && !instr_ext_i;
   assign neg = go && !repeat_valid_i && instr_word_i == `ANST_OPC_NEG;
   assign nop = go && !repeat_valid_i && instr_word_i == `ANST_OPC_NOP;
   assign nrm = go && !repeat_valid_i && instr_word_i[15:7] == 9'h141;
   assign trp = go && instr_word_i == `ANST_OPC_TRAP;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_one_step;
      busy_o ##1 (done_o && !busy_o);
   endsequence
   sequence s_trap_run;
      busy_o [*4] ##1 (done_o && flush_o && global_irq_mask_o);
   endsequence
   a_neg_value: assert property (neg |-> ##2 acc == ($past(acc, 2) != most_neg ?
      -$past(acc, 2) : $past(saturate_enable_i, 2) ? `ANST_ACC_MOST_POS : most_neg))
      else $error("negate result wrong");
   a_neg_carry: assert property (neg |-> ##2 carry_o == ($past(acc, 2) == 32'h0))
      else $error("negate carry wrong");
   a_neg_wrap: assert property (neg && acc == most_neg |-> ##2 arith_wrap_flag_o)
      else $error("wrap flag not set");
   a_one_step: assert property (neg || nop || nrm |-> ##1 s_one_step)
      else $error("single op timing wrong");
   a_trap_run: assert property (trp |-> ##1 s_trap_run ##0 pc_o == `ANST_TRAP_VECTOR)
      else $error("trap sequence wrong");
   a_trap_push: assert property (trp |-> ##6 stack_top_o == $past(pc_o, 6) + 16'h1)
      else $error("trap return address wrong");
   a_trap_keep: assert property (trp |-> ##5 acc == $past(acc, 5) &&
      carry_o == $past(carry_o, 5) && test_flag_o == $past(test_flag_o, 5))
      else $error("trap changed context");
   a_flush_words: assert property (flush_o |-> flush_words_o == 2'h2 && pc_o == 16'h0024)
      else $error("flush wrong");
   a_nop_keep: assert property (nop |-> ##2 pc_o == $past(pc_o, 2) + 16'h1 && acc == $past(acc, 2))
      else $error("no-operation changed state");
   a_sign_strip_step_op_zero: assert property (nrm && acc == 32'h0 |-> ##2 test_flag_o && acc == 32'h0)
      else $error("normalize of zero wrong");
   a_sign_strip_step_op_shift: assert property (nrm && acc != 32'h0 && acc[31] == acc[30] |-> ##2
      !test_flag_o && acc == $past(acc, 2) << 1 && carry_o == $past(carry_o, 2))
      else $error("normalize shift wrong");
endmodule // anst_chk
bind anst_core anst_chk u_anst_chk (.clk_i, .reset_i, .instr_valid_i, .instr_word_i, .instr_ext_i,
   .repeat_valid_i, .saturate_enable_i, .acc_load_i, .busy_o, .done_o, .flush_o, .flush_words_o,
   .main_result_register_o, .carry_o, .arith_wrap_flag_o, .test_flag_o, .global_irq_mask_o,
   .pc_o, .stack_top_o);
`default_nettype wire

/* sim/anst_core_tb.sv */
// self-checking bench for anst_core against a behavioural model
// assumes the checker is bound in separately
`timescale 1ns/1ps
`default_nettype none
`include "anst_regs.svh"
module anst_core_tb;
   logic        clk_i = 0, reset_i = 1, instr_valid_i = 0, instr_ext_i = 0, repeat_valid_i = 0;
   logic        saturate_enable_i = 0, aux_load_i = 0, acc_load_i = 0, irq_mask_clear_i = 0;
   logic [15:0] instr_word_i = 16'h0, aux_load_data_i = 16'h0, aux_index_i = 16'h0;
   logic [3:0]  wait_states_i = 4'h0;
   logic [7:0]  repeat_count_i = 8'h0;
   logic [2:0]  aux_pointer_select_i = 3'h0, aux_load_sel_i = 3'h0;
   logic [31:0] acc_load_data_i = 32'h0, main_result_register_o, m_acc = 32'h0;
   logic        busy_o, done_o, flush_o, carry_o, arith_wrap_flag_o, test_flag_o;
   logic        global_irq_mask_o, m_cy = 0, m_wr = 0, m_tf = 0, m_mk = 1;
   logic [1:0]  flush_words_o;
   logic [15:0] pc_o, stack_top_o, aux_register_o, m_pc = 16'h0, m_ar [8];
   logic [3:0]  stack_depth_o;
   logic [15:0] m_stk [$];
   int          n_fail = 0, checks = 0;
   always #4 clk_i = ~clk_i;
   anst_core u_anst_core (.clk_i, .reset_i, .instr_valid_i, .instr_word_i, .instr_ext_i,
      .wait_states_i, .repeat_valid_i, .repeat_count_i, .saturate_enable_i, .aux_pointer_select_i,
      .aux_load_i, .aux_load_sel_i, .aux_load_data_i, .aux_index_i, .acc_load_i, .acc_load_data_i,
      .irq_mask_clear_i, .busy_o, .done_o, .flush_o, .flush_words_o, .main_result_register_o,
      .carry_o, .arith_wrap_flag_o, .test_flag_o, .global_irq_mask_o, .pc_o, .stack_top_o,
      .stack_depth_o, .aux_register_o);
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic load(input logic [31:0] a, input logic [2:0] s, input logic [15:0] d);
      @(posedge clk_i);
      acc_load_i <= 1; acc_load_data_i <= a; aux_load_i <= 1; aux_load_sel_i <= s;
      aux_load_data_i <= d; aux_pointer_select_i <= s;
      @(posedge clk_i);
      acc_load_i <= 0; aux_load_i <= 0;
      m_acc = a; m_ar[s] = d;
   endtask
   task automatic exec(input logic [15:0] w, input logic e, input logic [3:0] p,
                       input logic r, input logic [7:0] n);
      int k, it; logic tr, stop;
      tr = (w === `ANST_OPC_TRAP);
      @(posedge clk_i);
      instr_valid_i <= 1; instr_word_i <= w; instr_ext_i <= e; wait_states_i <= p;
      repeat_valid_i <= r; repeat_count_i <= n;
      @(posedge clk_i);
      instr_valid_i <= 0;
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
      end while (done_o !== 1'b1 && k < 40);
      if (k >= 40) begin
         n_fail++;
         close_out();
      end
      if (tr) begin
         m_stk.push_back(m_pc + 16'h1);
         if (m_stk.size() > 8) void'(m_stk.pop_front());
         m_pc = `ANST_TRAP_VECTOR; m_mk = 1;
      end else m_pc = m_pc + 16'h1;
      if (w === `ANST_OPC_NEG) begin
         m_cy = (m_acc == 32'h0);
         if (m_acc == `ANST_ACC_MOST_NEG) begin
            m_wr = 1;
            if (saturate_enable_i) m_acc = `ANST_ACC_MOST_POS;
         end else m_acc = -m_acc;
      end
      stop = 0;
      if (w[15:7] === 9'h141) for (it = 0; it <= (r ? n : 0); it++) if (!stop) begin
         if (m_acc == 0 || m_acc[31] != m_acc[30]) begin
            m_tf = 1; stop = 1;
         end else begin
            m_tf = 0; m_acc = m_acc << 1;
            case (w[6:4])
               3'h0: ;
               3'h1: m_ar[aux_pointer_select_i] -= 16'h1;
               3'h5: m_ar[aux_pointer_select_i] -= aux_index_i;
               3'h6: m_ar[aux_pointer_select_i] += aux_index_i;
               default: m_ar[aux_pointer_select_i] += 16'h1;
            endcase
         end
      end
      chk("cycles", k - 1, tr ? 4 + (e ? 3 * p : 0) : 1 + (e ? p : 0) + (r ? n : 0));
      chk("flush", flush_o, tr);
      if (tr) chk("flush_words", flush_words_o, 32'h2);
      chk("acc", main_result_register_o, m_acc);
      chk("carry", carry_o, m_cy);
      chk("wrap", arith_wrap_flag_o, m_wr);
      chk("test", test_flag_o, m_tf);
      chk("mask", global_irq_mask_o, m_mk);
      chk("pc", pc_o, m_pc);
      @(negedge clk_i);
      chk("aux", aux_register_o, m_ar[aux_pointer_select_i]);
      chk("depth", stack_depth_o, m_stk.size());
      if (m_stk.size() > 0) chk("top", stack_top_o, m_stk[$]);
   endtask
   initial begin
      int i; logic [2:0] s; logic [31:0] a;
      void'($urandom(32'h285270F1));
      m_ar = '{default: 16'h0};
      aux_index_i = 16'($urandom);
      repeat (8) @(posedge clk_i);
      reset_i <= 0;
      @(negedge clk_i);
      chk("mask", global_irq_mask_o, 1'b1);
      chk("acc", main_result_register_o, 32'h0);
      $display("test reset done");
      for (i = 0; i < 6; i++) begin
         a = i == 0 ? 32'h0 : i < 3 ? `ANST_ACC_MOST_NEG : i == 3 ? 32'hFFFFF228 : $urandom;
         saturate_enable_i <= i[0];
         load(a, aux_pointer_select_i, m_ar[aux_pointer_select_i]);
         exec(`ANST_OPC_NEG, i[2], 4'($urandom % 5), 1'b0, 8'h0);
      end
      $display("test negate done");
      exec(`ANST_OPC_NOP, 1'b0, 4'h0, 1'b0, 8'h0);
      exec(`ANST_OPC_NOP, 1'b1, 4'h4, 1'b0, 8'h0);
      $display("test nop done");
      for (i = 0; i < 16; i++) begin
         // pointer moves only on a load, never within two words after a normalize
         s = 3'($urandom);
         a = i == 0 ? 32'h0 : i == 1 ? 32'h40000000 : $urandom >> (i % 9);
         load(a, s, 16'($urandom));
         exec({8'hA0, 1'b1, i[2:0], 4'h0}, i[3] & i[0], 4'($urandom % 5), i[3], 8'($urandom % 8));
      end
      $display("test normalize done");
      @(posedge clk_i);
      irq_mask_clear_i <= 1;
      @(posedge clk_i);
      irq_mask_clear_i <= 0;
      m_mk = 0;
      @(negedge clk_i);
      chk("mask", global_irq_mask_o, 1'b0);
      // repeat prefix present on every trap, it must be ignored
      for (i = 0; i < 9; i++) exec(`ANST_OPC_TRAP, i[0], 4'($urandom % 4), 1'b1, 8'h3);
      $display("test trap done");
      close_out();
   end
endmodule // anst_core_tb
`default_nettype wire
